// [gbtp_pkg.sv]
// Constants, register indices and carrier types for the burst timing port.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
// Operation
// - Host loads and reads device registers over a 16-bit parallel port.
// - Device holds a 148-bit transmit burst register filled by the host.
// - Modulation of the 148 bits starts when event time equals both counters.
// - Device signals the host once the last burst bit has been sent.
// - At receive start time the control field enables I/Q pair conversion.
// - Received I/Q pairs go into a double buffer, 32 pairs per half.
// - Device notifies host per full half; host reads it before the next fills.
// - Voice-band input raises an interrupt per completed 16-bit PCM word.
package gbtp_pkg;
    localparam int          DATA_W       = 16;
    localparam int          ADDR_W       = 6;
    localparam int          BURST_BITS   = 148;
    localparam int          BURST_WORDS  = 10;
    localparam int          PAIRS        = 32;
    localparam int          QB_W         = 13;
    localparam int          FN_W         = 16;
    localparam int          CLK_HZ       = 200000000;
    // Quarter-bit rate in hertz, four times the bit rate.
    localparam int          QBIT_HZ      = 1083332;
    localparam int          QBIT_CYC     = CLK_HZ / QBIT_HZ;
    localparam logic [7:0]  QBIT_DIV_MAX = 8'(QBIT_CYC - 1);
    // Last quarter-bit count of a frame; the counter wraps after it, giving 5000 per frame.
    localparam logic [12:0] QB_MAX       = 13'h1387;
    localparam logic [1:0]  QB_PER_BIT   = 2'h3;
    // Register indices on the parallel port.
    localparam logic [5:0]  A_BURST0     = 6'h00;
    localparam logic [5:0]  A_EVT_QB     = 6'h10;
    localparam logic [5:0]  A_EVT_FN     = 6'h11;
    localparam logic [5:0]  A_EVT_CTL    = 6'h12;
    localparam logic [5:0]  A_STATUS     = 6'h13;
    localparam logic [5:0]  A_QB_CNT     = 6'h14;
    localparam logic [5:0]  A_FN_CNT     = 6'h15;
    localparam logic [5:0]  A_PCM        = 6'h16;
    localparam logic [5:0]  A_RXBUF      = 6'h20;
    // Event control bits.
    localparam int          CTL_TX       = 0;
    localparam int          CTL_RX       = 1;
    localparam int          CTL_RX_STOP  = 2;
    localparam logic [15:0] ZERO16       = 16'h0000;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } gbtp_req_t;

    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } gbtp_iq_t;

    typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_RUN} gbtp_tx_t;
endpackage

// [gbtp_core.sv]
// Burst timing, receive double buffer and voice-band handshake.
// Assumes the host port, sample strobes and converter inputs are synchronous to clk.
`timescale 1ns/1ps
module gbtp_core
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire gbtp_pkg::gbtp_req_t host_req,
    output logic [15:0]            host_rdata,
    output logic                   tx_done_irq,
    output logic                   tx_bit,
    output logic                   tx_bit_valid,
    output logic                   tx_active,
    output logic                   rx_enable,
    input  wire logic              rx_pair_valid,
    input  wire gbtp_pkg::gbtp_iq_t  rx_pair,
    output logic                   rx_half_irq,
    output logic                   rx_overrun,
    input  wire logic              vb_word_done,
    input  wire logic [15:0]       vb_in_word,
    output logic                   vb_irq,
    output logic [15:0]            vb_out_word,
    output logic                   vb_out_load
);
    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    logic [7:0]   div_ff, nxt_div;
    logic [12:0]  qb_ff, nxt_qb;
    logic [15:0]  fn_ff, nxt_fn;
    logic [147:0] burst_ff, nxt_burst;
    logic [12:0]  evt_qb_ff, nxt_evt_qb;
    logic [15:0]  evt_fn_ff, nxt_evt_fn;
    logic [2:0]   ctl_ff, nxt_ctl;
    gbtp_pkg::gbtp_tx_t tx_st_ff, nxt_tx_st;
    logic [7:0]   bit_ix_ff, nxt_bit_ix;
    logic [1:0]   sub_ff, nxt_sub;
    logic         done_ff, nxt_done, txb_ff, nxt_txb, txv_ff, nxt_txv;
    logic         rxen_ff, nxt_rxen;
    logic         run_ff, nxt_run;
    gbtp_pkg::gbtp_iq_t buf_ff [2*gbtp_pkg::PAIRS];
    logic [5:0]   wptr_ff, nxt_wptr;
    logic [1:0]   full_ff, nxt_full;
    logic         half_irq_ff, nxt_half_irq, ovr_ff, nxt_ovr;
    logic         vbi_ff, nxt_vbi, vbl_ff, nxt_vbl;
    logic [15:0]  vbin_ff, nxt_vbin, vbout_ff, nxt_vbout, rd_ff, nxt_rd;
    logic         qtick, evt_hit;

    // ------------------------------------------------------------
    // Free-running timing and event logic.
    // ------------------------------------------------------------
    always_comb
    begin
        qtick      = (div_ff == gbtp_pkg::QBIT_DIV_MAX);
        nxt_div    = qtick ? 8'h00 : div_ff + 8'h01;
        nxt_qb     = qb_ff;
        nxt_fn     = fn_ff;
        if (qtick)
        begin
            nxt_qb = (qb_ff == gbtp_pkg::QB_MAX) ? 13'h0000 : qb_ff + 13'h0001;
            if (qb_ff == gbtp_pkg::QB_MAX)
            begin
                nxt_fn = fn_ff + 16'h0001;
            end
        end
        evt_hit    = qtick && (qb_ff == evt_qb_ff) && (fn_ff == evt_fn_ff);
        nxt_burst  = burst_ff;
        nxt_evt_qb = evt_qb_ff;
        nxt_evt_fn = evt_fn_ff;
        nxt_ctl    = ctl_ff;
        nxt_vbout  = vbout_ff;
        nxt_vbl    = 1'b0;
        if (host_req.wr)
        begin
            if (host_req.addr < 6'(gbtp_pkg::BURST_WORDS))
            begin
                for (int k = 0; k < gbtp_pkg::BURST_WORDS; k++)
                begin
                    for (int b = 0; b < gbtp_pkg::DATA_W; b++)
                    begin
                        if ((k * gbtp_pkg::DATA_W + b < gbtp_pkg::BURST_BITS)
                            && (host_req.addr == 6'(k)))
                        begin
                            nxt_burst[k * gbtp_pkg::DATA_W + b] = host_req.wdata[b];
                        end
                    end
                end
            end
            case (host_req.addr)
                gbtp_pkg::A_EVT_QB:  nxt_evt_qb = host_req.wdata[12:0];
                gbtp_pkg::A_EVT_FN:  nxt_evt_fn = host_req.wdata;
                gbtp_pkg::A_EVT_CTL: nxt_ctl    = host_req.wdata[2:0];
                gbtp_pkg::A_PCM:
                begin
                    nxt_vbout = host_req.wdata;
                    nxt_vbl   = 1'b1;
                end
                default: ;
            endcase
        end
        nxt_tx_st  = tx_st_ff;
        nxt_bit_ix = bit_ix_ff;
        nxt_sub    = sub_ff;
        nxt_done   = 1'b0;
        nxt_txv    = 1'b0;
        nxt_txb    = txb_ff;
        nxt_rxen   = rxen_ff;
        case (tx_st_ff)
            gbtp_pkg::TX_IDLE:
            begin
                if (ctl_ff[gbtp_pkg::CTL_TX])
                begin
                    nxt_tx_st = gbtp_pkg::TX_ARMED;
                end
            end
            gbtp_pkg::TX_ARMED:
            begin
                if (evt_hit)
                begin
                    nxt_tx_st  = gbtp_pkg::TX_RUN;
                    nxt_bit_ix = 8'h00;
                    nxt_sub    = 2'h0;
                end
            end
            gbtp_pkg::TX_RUN:
            begin
                if (qtick)
                begin
                    nxt_sub = sub_ff + 2'h1;
                    if (sub_ff == 2'h0)
                    begin
                        nxt_txb = burst_ff[bit_ix_ff];
                        nxt_txv = 1'b1;
                    end
                    if (sub_ff == gbtp_pkg::QB_PER_BIT)
                    begin
                        nxt_bit_ix = bit_ix_ff + 8'h01;
                        if (bit_ix_ff == 8'(gbtp_pkg::BURST_BITS - 1))
                        begin
                            nxt_tx_st = gbtp_pkg::TX_IDLE;
                            nxt_done  = 1'b1;
                        end
                    end
                end
            end
            default: nxt_tx_st = gbtp_pkg::TX_IDLE;
        endcase
        nxt_run    = (nxt_tx_st == gbtp_pkg::TX_RUN);
        if (nxt_done || (host_req.wr && host_req.addr == gbtp_pkg::A_EVT_CTL))
        begin
            if (nxt_done)
            begin
                nxt_ctl[gbtp_pkg::CTL_TX] = 1'b0;
            end
        end
        if (tx_st_ff == gbtp_pkg::TX_IDLE && ctl_ff[gbtp_pkg::CTL_TX])
        begin
            nxt_ctl[gbtp_pkg::CTL_TX] = ctl_ff[gbtp_pkg::CTL_TX];
        end
        if (ctl_ff[gbtp_pkg::CTL_RX] && evt_hit)
        begin
            nxt_rxen = 1'b1;
            nxt_ctl[gbtp_pkg::CTL_RX] = 1'b0;
        end
        if (ctl_ff[gbtp_pkg::CTL_RX_STOP])
        begin
            nxt_rxen = 1'b0;
            nxt_ctl[gbtp_pkg::CTL_RX_STOP] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receive double buffer, voice band and read mux.
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_wptr     = wptr_ff;
        nxt_full     = full_ff;
        nxt_half_irq = 1'b0;
        nxt_ovr      = 1'b0;
        if (rxen_ff && rx_pair_valid)
        begin
            nxt_wptr = wptr_ff + 6'h01;
            if (wptr_ff[4:0] == 5'(gbtp_pkg::PAIRS - 1))
            begin
                nxt_half_irq = 1'b1;
                nxt_ovr = full_ff[wptr_ff[5]];
                nxt_full[wptr_ff[5]] = 1'b1;
            end
        end
        if (host_req.rd && host_req.addr[5] && host_req.addr[4:0] == 5'(gbtp_pkg::PAIRS - 1))
        begin
            nxt_full[~wptr_ff[5]] = 1'b0;
        end
        nxt_vbi  = vb_word_done;
        nxt_vbin = vb_word_done ? vb_in_word : vbin_ff;
        nxt_rd   = gbtp_pkg::ZERO16;
        if (host_req.rd)
        begin
            if (host_req.addr[5])
            begin
                nxt_rd = buf_ff[{~wptr_ff[5], host_req.addr[4:0]}].i
                       ^ buf_ff[{~wptr_ff[5], host_req.addr[4:0]}].q;
            end
            else
            begin
                case (host_req.addr)
                    gbtp_pkg::A_EVT_QB:  nxt_rd = {3'h0, evt_qb_ff};
                    gbtp_pkg::A_EVT_FN:  nxt_rd = evt_fn_ff;
                    gbtp_pkg::A_EVT_CTL: nxt_rd = {13'h0000, ctl_ff};
                    gbtp_pkg::A_STATUS:  nxt_rd = {10'h000, full_ff, wptr_ff[5], rxen_ff,
                                                   (tx_st_ff == gbtp_pkg::TX_RUN),
                                                   (tx_st_ff == gbtp_pkg::TX_ARMED)};
                    gbtp_pkg::A_QB_CNT:  nxt_rd = {3'h0, qb_ff};
                    gbtp_pkg::A_FN_CNT:  nxt_rd = fn_ff;
                    gbtp_pkg::A_PCM:     nxt_rd = vbin_ff;
                    default:             nxt_rd = gbtp_pkg::ZERO16;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_ff      <= 8'h00;
            qb_ff       <= 13'h0000;
            fn_ff       <= 16'h0000;
            burst_ff    <= '0;
            evt_qb_ff   <= 13'h0000;
            evt_fn_ff   <= 16'h0000;
            ctl_ff      <= 3'h0;
            tx_st_ff    <= gbtp_pkg::TX_IDLE;
            bit_ix_ff   <= 8'h00;
            sub_ff      <= 2'h0;
            done_ff     <= 1'b0;
            txb_ff      <= 1'b0;
            txv_ff      <= 1'b0;
            rxen_ff     <= 1'b0;
            run_ff      <= 1'b0;
            wptr_ff     <= 6'h00;
            full_ff     <= 2'h0;
            half_irq_ff <= 1'b0;
            ovr_ff      <= 1'b0;
            vbi_ff      <= 1'b0;
            vbl_ff      <= 1'b0;
            vbin_ff     <= 16'h0000;
            vbout_ff    <= 16'h0000;
            rd_ff       <= 16'h0000;
        end
        else
        begin
            div_ff      <= nxt_div;
            qb_ff       <= nxt_qb;
            fn_ff       <= nxt_fn;
            burst_ff    <= nxt_burst;
            evt_qb_ff   <= nxt_evt_qb;
            evt_fn_ff   <= nxt_evt_fn;
            ctl_ff      <= nxt_ctl;
            tx_st_ff    <= nxt_tx_st;
            bit_ix_ff   <= nxt_bit_ix;
            sub_ff      <= nxt_sub;
            done_ff     <= nxt_done;
            txb_ff      <= nxt_txb;
            txv_ff      <= nxt_txv;
            rxen_ff     <= nxt_rxen;
            run_ff      <= nxt_run;
            wptr_ff     <= nxt_wptr;
            full_ff     <= nxt_full;
            half_irq_ff <= nxt_half_irq;
            ovr_ff      <= nxt_ovr;
            vbi_ff      <= nxt_vbi;
            vbl_ff      <= nxt_vbl;
            vbin_ff     <= nxt_vbin;
            vbout_ff    <= nxt_vbout;
            rd_ff       <= nxt_rd;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rxen_ff && rx_pair_valid)
        begin
            buf_ff[wptr_ff] <= rx_pair;
        end
    end

    assign host_rdata   = rd_ff;
    assign tx_done_irq  = done_ff;
    assign tx_bit       = txb_ff;
    assign tx_bit_valid = txv_ff;
    assign tx_active    = run_ff;
    assign rx_enable    = rxen_ff;
    assign rx_half_irq  = half_irq_ff;
    assign rx_overrun   = ovr_ff;
    assign vb_irq       = vbi_ff;
    assign vb_out_word  = vbout_ff;
    assign vb_out_load  = vbl_ff;
endmodule

// [gbtp_core_sva.sv]
// Concurrent checks on the ports of the burst timing core.
// Assumes one clock domain, clk, with sys_rst synchronous and active high.
`timescale 1ns/1ps
module gbtp_sva
(
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire gbtp_pkg::gbtp_req_t host_req,
    input wire logic [15:0]         host_rdata,
    input wire logic                tx_done_irq,
    input wire logic                tx_bit_valid,
    input wire logic                tx_active,
    input wire logic                rx_enable,
    input wire logic                rx_pair_valid,
    input wire logic                rx_half_irq,
    input wire logic                vb_word_done,
    input wire logic                vb_irq,
    input wire logic [15:0]         vb_out_word,
    input wire logic                vb_out_load
);
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_pcm_wr;
        host_req.wr && host_req.addr == gbtp_pkg::A_PCM;
    endsequence
    sequence s_bit_gap;
        !tx_bit_valid [*8];
    endsequence
    a_rdata_idle: assert property (!$past(host_req.rd) |-> host_rdata == 16'h0000)
        else $error("read data without a read");
    a_vb_irq_next: assert property (vb_word_done |=> vb_irq)
        else $error("voice interrupt missing");
    a_vb_irq_cause: assert property (vb_irq |-> $past(vb_word_done))
        else $error("voice interrupt without a word");
    a_pcm_load: assert property (s_pcm_wr |=> vb_out_load && vb_out_word == $past(host_req.wdata))
        else $error("output word not loaded");
    a_load_cause: assert property (vb_out_load |-> $past(host_req.wr) && $past(host_req.addr) == gbtp_pkg::A_PCM)
        else $error("output load without a write");
    a_bit_gap: assert property (tx_bit_valid |=> s_bit_gap)
        else $error("burst bits too close");
    a_bit_in_run: assert property (tx_bit_valid |-> tx_active)
        else $error("burst bit outside a burst");
    a_done_after_run: assert property (tx_done_irq |-> $past(tx_active))
        else $error("done without a burst");
    a_half_cause: assert property (rx_half_irq |-> $past(rx_pair_valid) && $past(rx_enable))
        else $error("half full without a pair");
endmodule

bind gbtp_core gbtp_sva u_gbtp_sva (.clk(clk), .sys_rst(sys_rst), .host_req(host_req),
    .host_rdata(host_rdata), .tx_done_irq(tx_done_irq), .tx_bit_valid(tx_bit_valid),
    .tx_active(tx_active), .rx_enable(rx_enable), .rx_pair_valid(rx_pair_valid),
    .rx_half_irq(rx_half_irq), .vb_word_done(vb_word_done), .vb_irq(vb_irq),
    .vb_out_word(vb_out_word), .vb_out_load(vb_out_load));

// [gbtp_host.sv]
// Host processor model on the 16-bit register port.
// Assumes the core answers a read in the cycle after the read strobe.
`timescale 1ns/1ps
module gbtp_host
(
    input  wire logic           clk,
    input  wire logic [15:0]    host_rdata,
    input  wire logic           vb_irq,
    output gbtp_pkg::gbtp_req_t host_req
);
    // ----------------------------------------------------------
    // Port cycles and voice service
    // ----------------------------------------------------------
    logic [15:0] pcm;
    initial host_req = '0;
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        host_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        host_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk);
        host_req <= '{1'b0, 1'b1, a, ~host_req.wdata};
        @(posedge clk);
        host_req <= '{1'b0, 1'b0, ~a, ~host_req.wdata};
        @(posedge clk);
        d = host_rdata;
    endtask
    always @(posedge clk)
        if (vb_irq === 1'b1)
        begin
            rd(gbtp_pkg::A_PCM, pcm);
            wr(gbtp_pkg::A_PCM, pcm ^ 16'h0FF0);
        end
endmodule

// [test_gsm_burst_timing_baseband_port.sv]
// Self-checking bench for the burst timing core with a host model.
// Assumes the 200 MHz clock and the register map of the package.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
`define WAITS(s, l) begin int n; n = 0; do begin @(posedge clk); n++; end \
    while ((s) !== 1'b1 && n < (l)); end
module test_gsm_burst_timing_baseband_port;
    // ----------------------------------------------------------
    // Bench
    // ----------------------------------------------------------
    logic                clk;
    logic                sys_rst;
    gbtp_pkg::gbtp_req_t host_req;
    gbtp_pkg::gbtp_iq_t  rx_pair;
    logic [15:0]         host_rdata, vb_in_word, vb_out_word;
    logic                tx_done_irq, tx_bit, tx_bit_valid, tx_active, rx_enable;
    logic                rx_pair_valid, rx_half_irq, rx_overrun, vb_word_done, vb_irq, vb_out_load;
    int                  miscompares, check_count;

    gbtp_core u_gbtp_core (.clk(clk), .sys_rst(sys_rst), .host_req(host_req),
        .host_rdata(host_rdata), .tx_done_irq(tx_done_irq), .tx_bit(tx_bit),
        .tx_bit_valid(tx_bit_valid), .tx_active(tx_active), .rx_enable(rx_enable),
        .rx_pair_valid(rx_pair_valid), .rx_pair(rx_pair), .rx_half_irq(rx_half_irq),
        .rx_overrun(rx_overrun), .vb_word_done(vb_word_done), .vb_in_word(vb_in_word),
        .vb_irq(vb_irq), .vb_out_word(vb_out_word), .vb_out_load(vb_out_load));
    gbtp_host u_gbtp_host (.clk(clk), .host_rdata(host_rdata), .vb_irq(vb_irq),
        .host_req(host_req));

    function automatic logic burst_bit(input int n);
        logic [15:0] w;
        w = 16'h3C5A ^ (16'(n / 16) * 16'h0101);
        return w[n % 16];
    endfunction
    task automatic evt(input logic [15:0] ctl);
        logic [15:0] q, f;
        u_gbtp_host.rd(gbtp_pkg::A_QB_CNT, q);
        u_gbtp_host.rd(gbtp_pkg::A_FN_CNT, f);
        q = q + 16'h0006;
        if (q > 16'h1387)
        begin
            q = q - 16'h1388;
            f = f + 16'h0001;
        end
        u_gbtp_host.wr(gbtp_pkg::A_EVT_QB, q);
        u_gbtp_host.wr(gbtp_pkg::A_EVT_FN, f);
        u_gbtp_host.wr(gbtp_pkg::A_EVT_CTL, ctl);
    endtask
    task automatic t_count;
        logic [15:0] a, b;
        u_gbtp_host.rd(gbtp_pkg::A_QB_CNT, a);
        repeat (733) @(posedge clk);
        u_gbtp_host.rd(gbtp_pkg::A_QB_CNT, b);
        `CHK(b, (a + 16'h0004) % 16'h1388)
        u_gbtp_host.rd(6'h17, b);
        `CHK(b, 16'h0000)
    endtask
    task automatic t_voice;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            vb_in_word   <= 16'h5A3C + 16'(k);
            vb_word_done <= 1'b1;
            @(posedge clk);
            vb_word_done <= 1'b0;
            vb_in_word   <= ~(16'h5A3C + 16'(k));
            `WAITS(vb_irq, 3)
            `CHK(vb_irq, 1'b1)
            `WAITS(vb_out_load, 20)
            `CHK({vb_out_load, vb_out_word}, {1'b1, (16'h5A3C + 16'(k)) ^ 16'h0FF0})
        end
    endtask
    task automatic t_rx;
        logic [15:0] d;
        `CHK(rx_enable, 1'b0)
        evt(16'h0002);
        `WAITS(rx_enable, 2000)
        `CHK(rx_enable, 1'b1)
        for (int k = 0; k < 32; k++)
        begin
            @(posedge clk);
            `CHK(rx_half_irq, 1'b0)
            rx_pair       <= '{16'(k), 16'hF00F};
            rx_pair_valid <= 1'b1;
            @(posedge clk);
            rx_pair_valid <= 1'b0;
            rx_pair       <= '{16'hFFFF, 16'(k)};
        end
        `WAITS(rx_half_irq, 3)
        `CHK(rx_half_irq, 1'b1)
        for (int k = 0; k < 32; k++)
        begin
            u_gbtp_host.rd(6'(gbtp_pkg::A_RXBUF + k), d);
            `CHK(d, 16'(k) ^ 16'hF00F)
        end
        u_gbtp_host.rd(gbtp_pkg::A_STATUS, d);
        `CHK(d[5:4], 2'b00)
        for (int k = 0; k < 96; k++)
        begin
            @(posedge clk);
            `CHK(rx_overrun, 1'b0)
            rx_pair       <= '{16'(k), 16'h0FF0};
            rx_pair_valid <= 1'b1;
            @(posedge clk);
            rx_pair_valid <= 1'b0;
        end
        `WAITS(rx_overrun, 3)
        `CHK(rx_overrun, 1'b1)
        u_gbtp_host.wr(gbtp_pkg::A_EVT_CTL, 16'h0004);
        repeat (2) @(posedge clk);
        `CHK(rx_enable, 1'b0)
    endtask
    task automatic t_tx;
        logic [15:0] d;
        for (int k = 0; k < 10; k++)
            u_gbtp_host.wr(6'(gbtp_pkg::A_BURST0 + k), 16'h3C5A ^ (16'(k) * 16'h0101));
        evt(16'h0001);
        for (int n = 0; n < 148; n++)
        begin
            `WAITS(tx_bit_valid, 2500)
            `CHK({tx_bit_valid, tx_bit, tx_active}, {1'b1, burst_bit(n), 1'b1})
        end
        `WAITS(tx_done_irq, 800)
        `CHK(tx_done_irq, 1'b1)
        `CHK(tx_active, 1'b0)
        u_gbtp_host.rd(gbtp_pkg::A_STATUS, d);
        `CHK(d[1:0], 2'b00)
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        #650000;
        miscompares++;
        complete_run;
    end
    initial
    begin
        sys_rst       = 1'b1;
        rx_pair_valid = 1'b0;
        rx_pair       = '0;
        vb_word_done  = 1'b0;
        vb_in_word    = 16'h0000;
        miscompares   = 0;
        check_count   = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_count;
        t_voice;
        t_rx;
        t_tx;
        complete_run;
    end
endmodule
